// ---- hdl/slp_ctrl.sv ----
// Purpose: sleep mode entry, wake-up and peripheral clock gating
// Assumes: core pulses i_sleep_instr one cycle; wake sources synchronous
// Notes:   clock enables are levels for external gating cells
`include "slp_map.svh"

module slp_ctrl
  import slp_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // core
  input  wire logic        i_sleep_instr,
  input  wire logic        i_sleep_enable_bit,
  input  wire logic [2:0]  i_sleep_mode_select,
  input  wire logic        i_global_irq_en,
  input  wire logic [7:0]  i_power_reduction_bits,
  // configuration
  input  wire logic        i_crystal_selected,
  input  wire logic [15:0] i_clock_select_fuses_startup,
  input  wire logic        i_debug_enable_fuse,
  input  wire logic        i_boundary_port_enable_fuse,
  input  wire logic        i_debug_port_disable_bit,
  input  wire logic        i_brownout_level_fuses_en,
  input  wire logic        i_adc_enable,
  input  wire logic        i_cmp_enable,
  input  wire logic        i_cmp_uses_vref,
  input  wire logic        i_wdt_enable,
  input  wire logic        i_async_timer_en,
  input  wire logic        i_async_timer_async_clk,
  input  wire logic [1:0]  i_async_timer_irq_mask,
  input  wire logic [7:0]  i_adc_input_disable_reg,
  input  wire logic [7:0]  i_comparator_input_disable_reg,
  input  wire logic [31:0] i_wake_pin_mask,
  // wake sources
  input  wire logic        i_ext_reset,
  input  wire logic        i_wdt_reset,
  input  wire logic        i_bod_reset,
  input  wire logic        i_wdt_irq,
  input  wire logic        i_adc_done_irq,
  input  wire logic        i_twi_irq,
  input  wire logic        i_twi_addr_match,
  input  wire logic [1:0]  i_async_timer_event,
  input  wire logic        i_store_ready_irq,
  input  wire logic        i_upper_external_irq_level,
  input  wire logic        i_low_external_irq_lines,
  input  wire logic        i_pin_change_irq,
  // clock enables
  output logic             o_core_clock_en,
  output logic             o_program_store_clock_en,
  output logic             o_io_clock_en,
  output logic             o_converter_clock_en,
  output logic             o_async_clock_en,
  output logic             o_main_osc_en,
  output logic             o_timer_osc_en,
  output logic [7:0]       o_periph_clock_en,
  // analog and supervisors
  output logic             o_adc_start,
  output logic             o_adc_extended,
  output logic             o_cmp_force_off,
  output logic             o_vref_en,
  output logic             o_wdt_run,
  output logic             o_bod_run,
  // pin buffers
  output logic [31:0]      o_pin_input_en,
  output logic [7:0]       o_adc_pin_input_en,
  output logic [7:0]       o_cmp_pin_input_en,
  // status
  output logic             o_sleeping,
  output logic             o_resume_pulse
);
  slp_st_t s_q;
  slp_st_t s_d;

  function automatic logic mode_known(input logic [2:0] m, input logic xtal);
    case (m)
      `SLP_MODE_IDLE, `SLP_MODE_ADCNR, `SLP_MODE_PDOWN, `SLP_MODE_PSAVE:
        mode_known = 1'b1;
      `SLP_MODE_STBY, `SLP_MODE_XSTBY: mode_known = xtal;
      default: mode_known = 1'b0;
    endcase
  endfunction : mode_known

  logic debug_on;
  logic tmr_wake;
  logic any_reset;
  logic wake_irq;
  logic wake_any;
  logic [15:0] startup_cnt;

  assign debug_on = i_debug_enable_fuse & i_boundary_port_enable_fuse
                  & ~i_debug_port_disable_bit;
  assign tmr_wake = i_async_timer_en & i_global_irq_en
                  & |(i_async_timer_irq_mask & i_async_timer_event);
  assign any_reset = i_ext_reset | i_wdt_reset | i_bod_reset;
  assign startup_cnt = (i_clock_select_fuses_startup == 16'h0000) ? 16'h0001
                     : i_clock_select_fuses_startup;

  always_comb begin
    wake_irq = 1'b0;
    case (s_q.mode)
      `SLP_MODE_IDLE: wake_irq = 1'b1;
      `SLP_MODE_ADCNR: wake_irq = i_adc_done_irq | i_wdt_irq | i_twi_irq
        | i_async_timer_event[0] | i_async_timer_event[1] | i_store_ready_irq
        | i_upper_external_irq_level | i_pin_change_irq;
      `SLP_MODE_PDOWN, `SLP_MODE_STBY: wake_irq = i_twi_addr_match
        | i_upper_external_irq_level | i_low_external_irq_lines
        | i_pin_change_irq | i_wdt_irq;
      `SLP_MODE_PSAVE, `SLP_MODE_XSTBY: wake_irq = i_twi_addr_match
        | i_upper_external_irq_level | i_low_external_irq_lines
        | i_pin_change_irq | i_wdt_irq | tmr_wake;
      default: wake_irq = 1'b0;
    endcase
    wake_any = wake_irq | any_reset;
  end

  always_comb begin
    logic sleeping;
    logic io_run;
    logic adc_run;
    logic deep;
    sleeping = 1'b0;
    io_run   = 1'b0;
    adc_run  = 1'b0;
    deep     = 1'b0;
    s_d = s_q;
    s_d.adc_start = 1'b0;
    s_d.resume    = 1'b0;
    case (s_q.state)
      SLP_ACTIVE: begin
        if (i_sleep_instr && i_sleep_enable_bit
            && mode_known(i_sleep_mode_select, i_crystal_selected)) begin
          s_d.state = SLP_SLEEP;
          s_d.mode  = i_sleep_mode_select;
          s_d.adc_start = (i_sleep_mode_select == `SLP_MODE_ADCNR)
                        & i_adc_enable;
        end
      end
      SLP_SLEEP: begin
        if (wake_any) begin
          s_d.is_irq = ~any_reset;
          s_d.state  = SLP_START;
          if (s_q.mode == `SLP_MODE_PDOWN || s_q.mode == `SLP_MODE_PSAVE)
            s_d.cnt = startup_cnt;
          else if (s_q.mode == `SLP_MODE_STBY || s_q.mode == `SLP_MODE_XSTBY)
            s_d.cnt = {12'h000, `SLP_STBY_WAKE_CYC};
          else
            s_d.cnt = 16'h0001;
        end
      end
      SLP_START: begin
        if (s_q.cnt > 16'h0001)
          s_d.cnt = s_q.cnt - 16'h0001;
        else if (s_q.is_irq) begin
          s_d.state = SLP_HALT;
          s_d.cnt   = {12'h000, `SLP_IRQ_HALT_CYC};
        end else begin
          s_d.state  = SLP_ACTIVE;
          s_d.resume = 1'b1;
        end
      end
      SLP_HALT: begin
        if (s_q.cnt > 16'h0001)
          s_d.cnt = s_q.cnt - 16'h0001;
        else begin
          s_d.state  = SLP_ACTIVE;
          s_d.resume = 1'b1;
        end
      end
      default: s_d.state = SLP_ACTIVE;
    endcase

    // clock domains follow the state being entered
    sleeping = (s_d.state != SLP_ACTIVE) && (s_d.state != SLP_HALT);
    s_d.core_en  = ~sleeping && (s_d.state != SLP_HALT);
    s_d.flash_en = s_d.core_en;
    s_d.asleep   = ~s_d.core_en;
    io_run  = ~sleeping || (s_d.mode == `SLP_MODE_IDLE);
    adc_run = ~sleeping || (s_d.mode == `SLP_MODE_IDLE)
            || (s_d.mode == `SLP_MODE_ADCNR);
    deep = sleeping && (s_d.mode != `SLP_MODE_IDLE) && (s_d.mode != `SLP_MODE_ADCNR);
    s_d.io_en  = io_run;
    s_d.adc_en = adc_run;
    case (sleeping ? s_d.mode : `SLP_MODE_IDLE)
      `SLP_MODE_IDLE, `SLP_MODE_ADCNR: begin
        s_d.asy_en  = i_async_timer_en && i_async_timer_async_clk;
        s_d.osc_en  = 1'b1;
        s_d.tosc_en = i_async_timer_async_clk;
      end
      `SLP_MODE_PSAVE: begin
        s_d.asy_en  = i_async_timer_en;
        s_d.osc_en  = i_async_timer_en && !i_async_timer_async_clk;
        s_d.tosc_en = i_async_timer_en && i_async_timer_async_clk;
      end
      `SLP_MODE_STBY: begin
        s_d.asy_en  = 1'b0;
        s_d.osc_en  = 1'b1;
        s_d.tosc_en = 1'b0;
      end
      `SLP_MODE_XSTBY: begin
        s_d.asy_en  = i_async_timer_en;
        s_d.osc_en  = 1'b1;
        s_d.tosc_en = i_async_timer_en && i_async_timer_async_clk;
      end
      default: begin
        s_d.asy_en  = 1'b0;
        s_d.osc_en  = 1'b0;
        s_d.tosc_en = 1'b0;
      end
    endcase
    if (debug_on)
      s_d.osc_en = 1'b1;
    // gating bit only matters while the io clock runs (the adc clock for the ADC bit); timer2 async escapes it
    for (int i = 0; i < `SLP_PERIPH_N; i++)
      s_d.periph_en[i] = io_run & ~i_power_reduction_bits[i];
    s_d.periph_en[`SLP_PR_ADC] = adc_run & ~i_power_reduction_bits[`SLP_PR_ADC];
    if (i_async_timer_async_clk)
      s_d.periph_en[`SLP_PR_TIM2] = s_d.asy_en;
    // an off-on cycle of the ADC forces a long first conversion
    s_d.adc_prev = i_adc_enable;
    if (i_adc_enable && !s_q.adc_prev)
      s_d.adc_ext = 1'b1;
    else if (s_q.adc_start || (i_adc_enable && adc_run && s_q.adc_ext && s_d.adc_start))
      s_d.adc_ext = s_q.adc_start ? 1'b0 : s_q.adc_ext;
    s_d.cmp_off = deep && !i_cmp_uses_vref;
    s_d.vref_en = i_brownout_level_fuses_en || i_adc_enable
                || (i_cmp_enable && (!s_d.cmp_off || i_cmp_uses_vref));
    s_d.wdt_run = i_wdt_enable;
    s_d.bod_run = i_brownout_level_fuses_en;
    s_d.inbuf_en = io_run || adc_run;
    for (int p = 0; p < `SLP_PINS_N; p++)
      s_d.pin_in_en[p] = s_d.inbuf_en || i_wake_pin_mask[p];
    s_d.ain_in_en = ~i_adc_input_disable_reg;
    s_d.ac_in_en  = ~i_comparator_input_disable_reg;
    if (i_srst) begin
      s_d = '0;
      s_d.state     = SLP_ACTIVE;
      s_d.core_en   = 1'b1;
      s_d.flash_en  = 1'b1;
      s_d.io_en     = 1'b1;
      s_d.adc_en    = 1'b1;
      s_d.osc_en    = 1'b1;
      s_d.periph_en = 8'hff;
      s_d.inbuf_en  = 1'b1;
      s_d.pin_in_en = 32'hffffffff;
      s_d.ain_in_en = 8'hff;
      s_d.ac_in_en  = 8'hff;
    end
  end

  always_ff @(posedge i_clock) begin
    s_q <= s_d;
  end

  assign o_core_clock_en          = s_q.core_en;
  assign o_program_store_clock_en = s_q.flash_en;
  assign o_io_clock_en            = s_q.io_en;
  assign o_converter_clock_en     = s_q.adc_en;
  assign o_async_clock_en         = s_q.asy_en;
  assign o_main_osc_en            = s_q.osc_en;
  assign o_timer_osc_en           = s_q.tosc_en;
  assign o_periph_clock_en        = s_q.periph_en;
  assign o_adc_start              = s_q.adc_start;
  assign o_adc_extended           = s_q.adc_ext;
  assign o_cmp_force_off          = s_q.cmp_off;
  assign o_vref_en                = s_q.vref_en;
  assign o_wdt_run                = s_q.wdt_run;
  assign o_bod_run                = s_q.bod_run;
  assign o_pin_input_en           = s_q.pin_in_en;
  assign o_adc_pin_input_en       = s_q.ain_in_en;
  assign o_cmp_pin_input_en       = s_q.ac_in_en;
  assign o_sleeping               = s_q.asleep;
  assign o_resume_pulse           = s_q.resume;
endmodule : slp_ctrl

// ---- hdl/slp_map.svh ----
// Purpose: constants for the sleep and clock gating controller
// Assumes: 25 MHz system clock
// Notes:   codes of the sleep mode select field and timing counts
`ifndef SLP_MAP_SVH
`define SLP_MAP_SVH
`define SLP_MODE_IDLE      3'h0
`define SLP_MODE_ADCNR     3'h1
`define SLP_MODE_PDOWN     3'h2
`define SLP_MODE_PSAVE     3'h3
`define SLP_MODE_STBY      3'h6
`define SLP_MODE_XSTBY     3'h7
`define SLP_STBY_WAKE_CYC  4'h6
`define SLP_IRQ_HALT_CYC   4'h4
`define SLP_PERIPH_N       8
`define SLP_PR_ADC         0
`define SLP_PR_TIM2        6
`define SLP_PINS_N         32
`define SLP_AIN_N          8
`define SLP_SUT_W          16
`endif

// ---- hdl/slp_pkg.sv ----
// Purpose: types for the sleep and clock gating controller
// Assumes: slp_map.svh holds the numbers
// Notes:   state codes written out
package slp_pkg;
  typedef enum logic [2:0] {
    SLP_ACTIVE = 3'h0,
    SLP_SLEEP  = 3'h1,
    SLP_START  = 3'h2,
    SLP_HALT   = 3'h3
  } slp_state_t;

  typedef struct packed {
    slp_state_t  state;
    logic [2:0]  mode;
    logic [15:0] cnt;
    logic        is_irq;
    logic        core_en;
    logic        flash_en;
    logic        io_en;
    logic        adc_en;
    logic        asy_en;
    logic        osc_en;
    logic        tosc_en;
    logic [7:0]  periph_en;
    logic        adc_start;
    logic        adc_ext;
    logic        adc_prev;
    logic        cmp_off;
    logic        vref_en;
    logic        wdt_run;
    logic        bod_run;
    logic        inbuf_en;
    logic [31:0] pin_in_en;
    logic [7:0]  ain_in_en;
    logic [7:0]  ac_in_en;
    logic        asleep;
    logic        resume;
  } slp_st_t;
endpackage : slp_pkg

// ---- sim/sleep_mode_clock_gating_test.sv ----
// Purpose: self-checking bench for slp_ctrl
// Assumes: start-up fuse count of ten
// Notes:   wake sources packed in wk, reset first
module sleep_mode_clock_gating_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock = 1'b0, i_srst = 1'b1, i_sleep_instr, i_sleep_enable_bit;
  logic [2:0]  i_sleep_mode_select;
  logic        i_global_irq_en = 1'b1, i_crystal_selected = 1'b1, i_cmp_uses_vref = 1'b0;
  logic        i_debug_enable_fuse = 1'b1, i_boundary_port_enable_fuse = 1'b1;
  logic        i_debug_port_disable_bit = 1'b1, i_brownout_level_fuses_en = 1'b1;
  logic        i_adc_enable = 1'b1, i_cmp_enable = 1'b1, i_wdt_enable = 1'b1;
  logic        i_async_timer_en = 1'b1, i_async_timer_async_clk = 1'b1;
  logic [1:0]  i_async_timer_irq_mask = 2'h1, i_async_timer_event;
  logic [7:0]  i_power_reduction_bits = 8'h00, i_adc_input_disable_reg = 8'h00;
  logic [7:0]  i_comparator_input_disable_reg = 8'h00, o_periph_clock_en;
  logic [7:0]  o_adc_pin_input_en, o_cmp_pin_input_en;
  logic [15:0] i_clock_select_fuses_startup = 16'h000a;
  logic [31:0] i_wake_pin_mask = 32'h0000_00f0, o_pin_input_en;
  logic [12:0] wk = 13'h0000;
  logic        i_ext_reset, i_wdt_reset, i_bod_reset, i_wdt_irq, i_adc_done_irq, i_twi_irq;
  logic        i_twi_addr_match, i_store_ready_irq, i_upper_external_irq_level;
  logic        i_low_external_irq_lines, i_pin_change_irq, o_resume_pulse, o_sleeping;
  logic        o_core_clock_en, o_program_store_clock_en, o_io_clock_en, o_converter_clock_en;
  logic        o_async_clock_en, o_main_osc_en, o_timer_osc_en, o_adc_start, o_adc_extended;
  logic        o_cmp_force_off, o_vref_en, o_wdt_run, o_bod_run;
  int          bad_count = 0, checked = 0, cycles = 0;
  assign {i_ext_reset, i_wdt_reset, i_bod_reset, i_wdt_irq, i_adc_done_irq, i_twi_irq,
          i_twi_addr_match, i_async_timer_event, i_store_ready_irq, i_upper_external_irq_level,
          i_low_external_irq_lines, i_pin_change_irq} = wk;
  slp_ctrl dut_u (.*);
  slp_core_model core_u (
    .i_clock             (i_clock),
    .i_resume_pulse      (o_resume_pulse),
    .o_sleep_instr       (i_sleep_instr),
    .o_sleep_enable_bit  (i_sleep_enable_bit),
    .o_sleep_mode_select (i_sleep_mode_select)
  );
  always #20 i_clock = ~i_clock;
  // whole run needs well under a thousand cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic refuse(input logic [2:0] m, input logic se);
    core_u.sleep_op(m, se);
    @(negedge i_clock);
    chk(o_sleeping, 1'b0, "refused entry");
  endtask : refuse
  // gate bits: core flash io adc asy osc tosc adcstart cmpoff
  task automatic sleep_wake(input logic [2:0] m, input logic [8:0] gate,
      input logic [12:0] nope, yes, input int n_up, n_halt);
    int up;
    int hold;
    up = 0;
    hold = 0;
    core_u.sleep_op(m, 1'b1);
    chk({o_core_clock_en, o_program_store_clock_en, o_io_clock_en, o_converter_clock_en,
      o_async_clock_en, o_main_osc_en, o_timer_osc_en, o_adc_start, o_cmp_force_off}, gate,
      "gating");
    chk(o_pin_input_en, (m == 3'h1) ? 32'hffffffff : i_wake_pin_mask, "buffers");
    chk(o_wdt_run, 1'b1, "wdt stopped");
    wk = nope;
    repeat (3) @(negedge i_clock);
    chk(o_sleeping, 1'b1, "wrong source woke");
    wk = yes;
    for (int i = 0; i < 400 && !o_resume_pulse; i++) begin
      @(negedge i_clock);
      wk = 13'h0000;
      up += int'(!o_io_clock_en);
      hold += int'(o_io_clock_en && !o_core_clock_en);
    end
    chk(up, n_up, "start-up");
    chk(hold, n_halt, "halt");
    chk(o_core_clock_en, 1'b1, "core back");
    $display("test mode %0d done", m);
  endtask : sleep_wake
  initial begin
    repeat (16) @(negedge i_clock);
    i_srst = 1'b0;
    {i_adc_enable, i_cmp_enable, i_brownout_level_fuses_en} = 3'h0;
    repeat (2) @(negedge i_clock);
    chk(o_vref_en, 1'b0, "vref idle");
    i_adc_enable = 1'b1;
    repeat (2) @(negedge i_clock);
    chk({o_vref_en, o_adc_extended}, 2'h3, "vref");
    {i_cmp_enable, i_brownout_level_fuses_en, i_adc_enable} = 3'h6;
    @(negedge i_clock);
    i_power_reduction_bits = 8'h81;
    repeat (2) @(negedge i_clock);
    chk({o_periph_clock_en, o_bod_run}, 9'h0fd, "reduction");
    {i_power_reduction_bits, i_adc_enable} = 9'h001;
    i_adc_input_disable_reg = 8'h0f;
    i_comparator_input_disable_reg = 8'h03;
    repeat (2) @(negedge i_clock);
    chk({o_periph_clock_en, o_adc_pin_input_en, o_cmp_pin_input_en}, 24'hfff0fc, "buf");
    $display("test active done");
    refuse(3'h2, 1'b0);
    for (int c = 4; c < 6; c++) refuse(3'(c), 1'b1);
    i_crystal_selected = 1'b0;
    refuse(3'h6, 1'b1);
    refuse(3'h7, 1'b1);
    i_crystal_selected = 1'b1;
    sleep_wake(3'h1, 9'h03e, 13'h0002, 13'h0100, 1, 4);
    chk(o_adc_extended, 1'b0, "extended");
    sleep_wake(3'h2, 9'h001, 13'h0100, 13'h0002, 10, 4);
    sleep_wake(3'h3, 9'h015, 13'h0028, 13'h0010, 10, 4);
    sleep_wake(3'h6, 9'h009, 13'h0010, 13'h0001, 6, 4);
    sleep_wake(3'h7, 9'h01d, 13'h0008, 13'h1000, 6, 0);
    // timer on the main clock keeps the oscillator, not the timer one
    i_async_timer_async_clk = 1'b0;
    sleep_wake(3'h3, 9'h019, 13'h0028, 13'h0010, 10, 4);
    i_debug_port_disable_bit = 1'b0;
    i_cmp_uses_vref = 1'b1;
    sleep_wake(3'h2, 9'h008, 13'h0100, 13'h0002, 10, 4);
    end_sim();
  end
endmodule : sleep_mode_clock_gating_test

// ---- sim/slp_core_model.sv ----
// Purpose: core side issuing sleep instructions
// Assumes: driven at falling edges
// Notes:   enable bit dropped on resume
module slp_core_model (
  // clock and status
  input  wire logic  i_clock,
  input  wire logic  i_resume_pulse,
  // sleep request
  output logic       o_sleep_instr,
  output logic       o_sleep_enable_bit,
  output logic [2:0] o_sleep_mode_select
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_sleep_instr = 1'b0;
    o_sleep_enable_bit = 1'b0;
    o_sleep_mode_select = 3'h0;
  end
  always @(negedge i_clock) if (i_resume_pulse) o_sleep_enable_bit = 1'b0;
  task automatic sleep_op(input logic [2:0] m, input logic se);
    @(negedge i_clock);
    o_sleep_mode_select = m;
    o_sleep_enable_bit = se;
    @(negedge i_clock);
    o_sleep_instr = 1'b1;
    @(negedge i_clock);
    o_sleep_instr = 1'b0;
  endtask : sleep_op
endmodule : slp_core_model

// ---- sim/slp_ctrl_chk.sv ----
// Purpose: port assertions for slp_ctrl
// Assumes: outputs follow inputs by one edge
// Notes:   bound into every slp_ctrl
module slp_ctrl_chk (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_srst,
  // inputs
  input wire logic        i_sleep_instr,
  input wire logic        i_sleep_enable_bit,
  input wire logic [2:0]  i_sleep_mode_select,
  input wire logic        i_crystal_selected,
  input wire logic        i_adc_enable,
  input wire logic        i_wdt_enable,
  input wire logic [31:0] i_wake_pin_mask,
  // outputs
  input wire logic        o_core_clock_en,
  input wire logic        o_program_store_clock_en,
  input wire logic        o_io_clock_en,
  input wire logic        o_converter_clock_en,
  input wire logic        o_main_osc_en,
  input wire logic [7:0]  o_periph_clock_en,
  input wire logic        o_adc_start,
  input wire logic        o_wdt_run,
  input wire logic [31:0] o_pin_input_en,
  input wire logic        o_sleeping
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  wire logic       take = i_sleep_instr && i_sleep_enable_bit && !o_sleeping;
  wire logic [2:0] md   = i_sleep_mode_select;
  adcnr_gate_a: assert property (take && md == 3'h1 |=> !o_core_clock_en &&
    !o_program_store_clock_en && !o_io_clock_en && o_converter_clock_en) else $error("adcnr");
  adc_kick_a: assert property (take && md == 3'h1 && i_adc_enable |=> o_adc_start)
    else $error("no adc start");
  pdown_gate_a: assert property (take && md == 3'h2 |=> !o_io_clock_en &&
    !o_converter_clock_en) else $error("pdown clock on");
  stby_osc_a: assert property (take && md == 3'h6 && i_crystal_selected |=>
    o_main_osc_en && !o_io_clock_en) else $error("standby osc");
  no_enable_a: assert property (i_sleep_instr && !i_sleep_enable_bit && !o_sleeping
    |=> !o_sleeping) else $error("slept unenabled");
  reserved_a: assert property (take && md[2:1] == 2'h2 |=> !o_sleeping)
    else $error("reserved slept");
  periph_off_a: assert property (!o_io_clock_en |->
    {o_periph_clock_en[7], o_periph_clock_en[5:1]} == 6'h00) else $error("periph on");
  wdt_keep_a: assert property (i_wdt_enable |=> o_wdt_run) else $error("wdt stop");
  inbuf_off_a: assert property (!o_io_clock_en && !o_converter_clock_en |->
    (o_pin_input_en & ~$past(i_wake_pin_mask)) == 32'h0) else $error("buffer on");
  enter_adcnr_c: cover property (take && md == 3'h1);
  enter_psave_c: cover property (take && md == 3'h3);
  enter_xstby_c: cover property (take && md == 3'h7);
endmodule : slp_ctrl_chk

bind slp_ctrl slp_ctrl_chk chk_u (.*);
